/* File: hw/htrf_framer.sv */
/*
 * Touch and pen input report framer with its byte FIFO.
 * Assumes event sources on the same clock holding valid until ready,
 * a byte sink with valid/ready, and a pull-up on the pending line.
 */
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "htrf_regs.svh"

// Byte FIFO; structure set by width and depth
module htrf_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk, // Core clock
    input wire logic i_sys_rst, // Async reset
    input wire logic i_in_valid, // Write request
    output logic o_in_ready, // Not full
    input wire logic [W-1:0] i_in_data, // Write data
    output logic o_out_valid, // Not empty
    input wire logic i_out_ready, // Drain request
    output logic [W-1:0] o_out_data, // Head word
    output logic [$clog2(DEPTH):0] o_level // Words held
);
    // Count is one bit wider so full and empty never alias
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } htrf_fifo_state_t;
    htrf_fifo_state_t s_q, s_d;
    logic push, pop;

    // Flags straight from the count, never guessed from pointers
    assign o_in_ready = s_q.cnt != (AW+1)'(DEPTH);
    assign o_out_valid = s_q.cnt != '0;
    assign o_out_data = s_q.mem[s_q.rp];
    assign o_level = s_q.cnt;
    assign push = i_in_valid && o_in_ready;
    assign pop = i_out_ready && o_out_valid;

    // Next state
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = i_in_data;
            s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
        end
        // Push and pop in one cycle leave the count unchanged
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // Reset empties the queue; stored bytes are lost
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// Overview of operation
// [RULE1] One report per active touch, each opening with the report identifier byte.
// [RULE2] Seventeen bytes follow the identifier in every per-touch report.
// [RULE3] Geometry on: status, number, X, X', Y, Y', width, height, scan time, count.
// [RULE4] Geometry off: same places, bytes 5, 6, 9, 10 and 11 to 14 reserved.
// [RULE5] Touch number byte names the touch, counted from zero.
// [RULE6] Coordinates are 12-bit; upper nibble of each high byte is zero.
// [RULE7] Geometry on: width in byte 11, height in byte 13.
// [RULE8] Bytes 15 and 16 hold a timestamp ticking every 100 us.
// [RULE9] Pen report opens with its identifier, a parameter.
// [RULE10] Pen byte 1: bit 0 tip contact, bit 1 barrel, bit 2 eraser.
// [RULE11] Pen byte 1: bit 4 in range; bits 3 and 7 to 5 reserved.
// [RULE12] Pen X, X centre, Y, Y centre in bytes 2-3, 4-5, 6-7, 8-9.
// [RULE13] Pen byte 10 carries tip pressure.
// [RULE14] Pending line pulled low while a report waits to be read.
// [RULE15] Two-byte fields go low byte first.
// [RULE16] Reserved bits and bytes are sent as zero.
module htrf_framer #(
    parameter logic [7:0] TOUCH_REPORT_ID = 8'h01,
    parameter logic [7:0] PEN_REPORT_ID = 8'h06,
    parameter int unsigned SCAN_TICK_CYC = `HTRF_SCAN_PERIOD_NS / `HTRF_CLK_PERIOD_NS,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic i_clk, // Core clock
    input wire logic i_sys_rst, // Async reset, high
    input wire logic [`HTRF_ADDR_W-1:0] i_addr, // Register address
    input wire logic [31:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [31:0] o_rdata, // Read data, cycle after strobe
    input wire logic i_touch_valid, // Touch event offered
    input wire htrf_pkg::htrf_touch_t i_touch, // Touch event
    output logic o_touch_ready, // Touch event taken
    input wire logic i_pen_valid, // Pen event offered
    input wire htrf_pkg::htrf_pen_t i_pen, // Pen event
    output logic o_pen_ready, // Pen event taken
    output logic o_byte_valid, // Report byte offered
    output logic [7:0] o_byte_data, // Report byte
    input wire logic i_byte_ready, // Sink takes byte
    output logic o_message_pending_n, // Pending pin level
    output logic o_message_pending_n_oe // Pending pin drive
);
    import htrf_pkg::*;

    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    // Whole framer state; one register, one next-state process
    typedef struct packed {
        htrf_state_t st;
        logic [4:0] idx;
        logic [4:0] len;
        logic [17:0][7:0] rpt;
        logic [15:0] div;
        logic [15:0] scan;
        logic geo_en;
        logic [31:0] rdata;
        logic ready;
        logic pen_rdy;
        logic out_valid;
        logic [7:0] out_data;
        logic pend_oe;
    } htrf_top_state_t;

    htrf_top_state_t s_q, s_d;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [7:0] f_out_data;
    logic [LW-1:0] f_level;
    logic take_touch, take_pen;

    // Per-touch report image, reserved places left at zero
    function automatic logic [17:0][7:0] fmt_touch(htrf_touch_t t, logic geo,
                                                   logic [15:0] scan);
        logic [17:0][7:0] r;
        r = '0; // RULE16
        r[`HTRF_T_ID] = TOUCH_REPORT_ID; // RULE1
        r[`HTRF_T_STATUS] = t.status; // RULE2
        r[`HTRF_T_NUM] = t.touch_num; // RULE5
        r[`HTRF_T_X] = t.x[7:0]; // RULE15
        r[`HTRF_T_X+1] = {`HTRF_COORD_PAD, t.x[11:8]}; // RULE6
        r[`HTRF_T_Y] = t.y[7:0]; // RULE15
        r[`HTRF_T_Y+1] = {`HTRF_COORD_PAD, t.y[11:8]}; // RULE6
        // Geometry off leaves X', Y', width and height at zero
        if (geo) begin
            r[`HTRF_T_XP] = t.x_alt[7:0]; // RULE3
            r[`HTRF_T_XP+1] = {`HTRF_COORD_PAD, t.x_alt[11:8]}; // RULE6
            r[`HTRF_T_YP] = t.y_alt[7:0]; // RULE3
            r[`HTRF_T_YP+1] = {`HTRF_COORD_PAD, t.y_alt[11:8]}; // RULE6
            r[`HTRF_T_WIDTH] = t.width; // RULE7
            r[`HTRF_T_HEIGHT] = t.height; // RULE7
        end // RULE4
        // Scan time is the value seen at the accept edge
        r[`HTRF_T_SCAN] = scan[7:0]; // RULE8
        r[`HTRF_T_SCAN+1] = scan[15:8]; // RULE15
        r[`HTRF_T_COUNT] = t.count; // RULE3
        return r;
    endfunction

    // Pen report image in the low eleven bytes
    function automatic logic [17:0][7:0] fmt_pen(htrf_pen_t p);
        logic [17:0][7:0] r;
        r = '0; // RULE16
        r[`HTRF_P_ID] = PEN_REPORT_ID; // RULE9
        // Bit 3 and bits 7 to 5 of byte 1 stay zero from the clear
        r[`HTRF_P_BTN][`HTRF_P_TIP_BIT] = p.tip; // RULE10
        r[`HTRF_P_BTN][`HTRF_P_BARREL_BIT] = p.barrel; // RULE10
        r[`HTRF_P_BTN][`HTRF_P_ERASER_BIT] = p.eraser; // RULE10
        r[`HTRF_P_BTN][`HTRF_P_RANGE_BIT] = p.in_range; // RULE11
        r[`HTRF_P_X] = p.x[7:0]; // RULE12
        r[`HTRF_P_X+1] = p.x[15:8]; // RULE15
        r[`HTRF_P_XC] = p.x_ctr[7:0]; // RULE12
        r[`HTRF_P_XC+1] = p.x_ctr[15:8]; // RULE15
        r[`HTRF_P_Y] = p.y[7:0]; // RULE12
        r[`HTRF_P_Y+1] = p.y[15:8]; // RULE15
        r[`HTRF_P_YC] = p.y_ctr[7:0]; // RULE12
        r[`HTRF_P_YC+1] = p.y_ctr[15:8]; // RULE15
        r[`HTRF_P_PRESS] = p.pressure; // RULE13
        return r;
    endfunction

    // Grants are registered and never both high, so a tie is settled
    // one cycle ahead; a pen offered during a touch grant waits a cycle
    assign take_touch = s_q.ready && i_touch_valid;
    assign take_pen = s_q.pen_rdy && i_pen_valid;

    // Byte walk feeds the FIFO; a full FIFO stalls the walk
    assign f_in_valid = s_q.st != HTRF_ST_IDLE;
    assign f_out_ready = !s_q.out_valid || i_byte_ready;

    // Sixteen bytes absorb most of a report while the host is slow
    htrf_fifo #(
        .W(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(f_in_valid),
        .o_in_ready(f_in_ready),
        .i_in_data(s_q.rpt[s_q.idx]),
        .o_out_valid(f_out_valid),
        .i_out_ready(f_out_ready),
        .o_out_data(f_out_data),
        .o_level(f_level)
    );

    // Next state of the whole framer
    always_comb begin
        s_d = s_q;
        // Scan timestamp, one tick per 100 us
        // Limitation: a 16-bit field wraps after about 6.5 s
        if (s_q.div == 16'(SCAN_TICK_CYC - 1)) begin
            s_d.div = '0;
            s_d.scan = s_q.scan + 16'h0001; // RULE8
        end else begin
            s_d.div = s_q.div + 16'h0001;
        end
        // Capture a whole report so the source is free at once
        case (s_q.st)
            HTRF_ST_IDLE: begin
                // Index restarts so each report begins with its identifier
                s_d.idx = '0;
                if (take_touch) begin
                    s_d.rpt = fmt_touch(i_touch, s_q.geo_en, s_q.scan); // RULE1
                    s_d.len = `HTRF_TOUCH_LEN; // RULE2
                    s_d.st = HTRF_ST_TOUCH;
                end else if (take_pen) begin
                    s_d.rpt = fmt_pen(i_pen); // RULE9
                    s_d.len = `HTRF_PEN_LEN;
                    s_d.st = HTRF_ST_PEN;
                end
            end
            HTRF_ST_TOUCH, HTRF_ST_PEN: begin
                // A full FIFO holds the index; the same byte is offered again
                if (f_in_ready) begin
                    s_d.idx = s_q.idx + 5'd1;
                    if (s_q.idx == s_q.len - 5'd1) begin
                        s_d.st = HTRF_ST_IDLE;
                    end
                end
            end
            default: begin
                s_d.st = HTRF_ST_IDLE;
            end
        endcase
        // One grant at a time; touch wins a tie, finger traffic is latency-critical
        s_d.ready = (s_d.st == HTRF_ST_IDLE) && (i_touch_valid || !i_pen_valid);
        s_d.pen_rdy = (s_d.st == HTRF_ST_IDLE) && !i_touch_valid && i_pen_valid;
        // Output stage so the sink sees flip-flops only
        if (f_out_ready) begin
            s_d.out_valid = f_out_valid;
            s_d.out_data = f_out_valid ? f_out_data : '0;
        end
        // Low while any byte of a report is still inside
        s_d.pend_oe = (s_d.st != HTRF_ST_IDLE) || (f_level > LW'(f_out_ready && f_out_valid))
                      || s_d.out_valid; // RULE14
        // Register writes
        if (i_wr && i_addr == `HTRF_REG_CTRL) begin
            s_d.geo_en = i_wdata[`HTRF_CTRL_GEO_BIT]; // RULE3
        end
        // Register reads, data for one cycle only
        // Busy and level let software see a backed-up host
        s_d.rdata = '0;
        if (i_rd) begin
            case (i_addr)
                `HTRF_REG_CTRL: s_d.rdata[`HTRF_CTRL_GEO_BIT] = s_q.geo_en;
                `HTRF_REG_STAT: begin
                    s_d.rdata[LW-1:0] = f_level;
                    s_d.rdata[`HTRF_STAT_BUSY_BIT] = s_q.st != HTRF_ST_IDLE;
                end
                `HTRF_REG_SCAN: s_d.rdata[15:0] = s_q.scan;
                default: s_d.rdata = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q <= '0;
            s_q.st <= HTRF_ST_IDLE;
            s_q.geo_en <= `HTRF_CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs, all from flip-flops except the pending pin level, tied to a constant
    assign o_rdata = s_q.rdata;
    assign o_touch_ready = s_q.ready;
    // Pen grant is a flip-flop too, decided one cycle ahead
    assign o_pen_ready = s_q.pen_rdy;
    assign o_byte_valid = s_q.out_valid;
    assign o_byte_data = s_q.out_data;
    // Open drain: only ever pulls low
    // Released at reset, so the pull-up holds the pin high
    assign o_message_pending_n = 1'b0;
    assign o_message_pending_n_oe = s_q.pend_oe; // RULE14
endmodule

/* File: hw/htrf_regs.svh */
/*
 * Constants of the touch report framer: register map, report layout,
 * timing. Assumes a 100 MHz core clock.
 */
`ifndef HTRF_REGS_SVH
`define HTRF_REGS_SVH

// Timing
`define HTRF_CLK_PERIOD_NS 10
`define HTRF_SCAN_PERIOD_NS 100000

// Register offsets and reset values
`define HTRF_ADDR_W 4
`define HTRF_REG_CTRL 4'h0
`define HTRF_REG_STAT 4'h4
`define HTRF_REG_SCAN 4'h8
`define HTRF_CTRL_GEO_BIT 0
`define HTRF_CTRL_RST 1'b0
`define HTRF_STAT_BUSY_BIT 8

// Report lengths in bytes, identifier included
`define HTRF_TOUCH_LEN 5'd18
`define HTRF_PEN_LEN 5'd11

// Per-touch report byte places
`define HTRF_T_ID 0
`define HTRF_T_STATUS 1
`define HTRF_T_NUM 2
`define HTRF_T_X 3
`define HTRF_T_XP 5
`define HTRF_T_Y 7
`define HTRF_T_YP 9
`define HTRF_T_WIDTH 11
`define HTRF_T_HEIGHT 13
`define HTRF_T_SCAN 15
`define HTRF_T_COUNT 17

// Pen report byte places and byte-1 bits
`define HTRF_P_ID 0
`define HTRF_P_BTN 1
`define HTRF_P_X 2
`define HTRF_P_XC 4
`define HTRF_P_Y 6
`define HTRF_P_YC 8
`define HTRF_P_PRESS 10
`define HTRF_P_TIP_BIT 0
`define HTRF_P_BARREL_BIT 1
`define HTRF_P_ERASER_BIT 2
`define HTRF_P_RANGE_BIT 4

// Upper nibble of a 12-bit coordinate high byte
`define HTRF_COORD_PAD 4'h0

`endif

/* File: hw/htrf_pkg.sv */
/*
 * Types of the touch report framer: event carriers and states.
 * Assumes htrf_regs.svh for all numeric constants.
 */
package htrf_pkg;

    // One active touch, as delivered by the touch tracker
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] touch_num;
        logic [11:0] x;
        logic [11:0] x_alt;
        logic [11:0] y;
        logic [11:0] y_alt;
        logic [7:0] width;
        logic [7:0] height;
        logic [7:0] count;
    } htrf_touch_t;

    // One pen sample
    typedef struct packed {
        logic tip;
        logic barrel;
        logic eraser;
        logic in_range;
        logic [15:0] x;
        logic [15:0] x_ctr;
        logic [15:0] y;
        logic [15:0] y_ctr;
        logic [7:0] pressure;
    } htrf_pen_t;

    // Framer states, one-hot
    typedef enum logic [2:0] {
        HTRF_ST_IDLE = 3'b001,
        HTRF_ST_TOUCH = 3'b010,
        HTRF_ST_PEN = 3'b100
    } htrf_state_t;

endpackage

/* File: testbench/htrf_framer_monitor.sv */
/*
 * Port checker of the report framer.
 * Assumes it sees the top ports only and that byte counting starts at reset.
 */
`timescale 1ns/10ps
module htrf_framer_monitor #(
    parameter logic [7:0] TOUCH_REPORT_ID = 8'h01,
    parameter logic [7:0] PEN_REPORT_ID = 8'h06
) (
    input wire logic i_clk, // Core clock
    input wire logic i_sys_rst, // Async reset
    input wire logic i_touch_valid, // Touch offered
    input wire logic o_touch_ready, // Touch taken
    input wire logic o_byte_valid, // Byte offered
    input wire logic [7:0] o_byte_data, // Byte
    input wire logic i_byte_ready, // Sink ready
    input wire logic o_message_pending_n, // Pin level
    input wire logic o_message_pending_n_oe // Pin drive
);
    logic take;
    logic [4:0] idx_q;
    logic pen_q;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    assign take = o_byte_valid && i_byte_ready;
    // Position inside the current report; length follows the leading id
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            idx_q <= 5'h0;
            pen_q <= 1'b0;
        end else if (take) begin
            if (idx_q == 5'h0) begin
                pen_q <= (o_byte_data == PEN_REPORT_ID);
            end
            idx_q <= (idx_q == (pen_q ? 5'd10 : 5'd17)) ? 5'h0 : idx_q + 5'h1;
        end
    end
    id_first_a: assert property (take && idx_q == 5'h0 |->
        o_byte_data == TOUCH_REPORT_ID || o_byte_data == PEN_REPORT_ID) else $error("bad id");
    coord_pad_a: assert property (take && !pen_q && idx_q inside {4, 6, 8, 10} |->
        o_byte_data[7:4] == 4'h0) else $error("coordinate nibble set");
    rsvd_zero_a: assert property (take && !pen_q && idx_q inside {12, 14} |->
        o_byte_data == 8'h0) else $error("reserved byte set");
    pen_rsvd_a: assert property (take && pen_q && idx_q == 5'h1 |->
        o_byte_data[7:5] == 3'h0 && !o_byte_data[3]) else $error("pen reserved bit");
    pend_busy_a: assert property (o_byte_valid |-> o_message_pending_n_oe)
        else $error("byte waits without pending");
    pend_low_a: assert property (o_message_pending_n_oe |-> !o_message_pending_n)
        else $error("pending drives high");
    accept_a: assert property (i_touch_valid && o_touch_ready |=> !o_touch_ready)
        else $error("ready after accept");
    hold_byte_a: assert property (o_byte_valid && !i_byte_ready |=>
        o_byte_valid && $stable(o_byte_data)) else $error("byte dropped");
endmodule
bind htrf_framer htrf_framer_monitor #(.TOUCH_REPORT_ID(TOUCH_REPORT_ID),
    .PEN_REPORT_ID(PEN_REPORT_ID)) i_htrf_framer_monitor (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_touch_valid(i_touch_valid), .o_touch_ready(o_touch_ready), .o_byte_valid(o_byte_valid),
    .o_byte_data(o_byte_data), .i_byte_ready(i_byte_ready),
    .o_message_pending_n(o_message_pending_n),
    .o_message_pending_n_oe(o_message_pending_n_oe));

/* File: testbench/htrf_host_model.sv */
/*
 * Host side reading report bytes into a queue.
 * Assumes the bench sets i_stall to hold the stream back.
 */
`timescale 1ns/10ps
module htrf_host_model (
    input wire logic i_clk, // Core clock
    input wire logic i_sys_rst, // Async reset
    input wire logic i_valid, // Byte offered
    input wire logic [7:0] i_data, // Byte
    input wire logic i_stall, // Hold reads back
    output logic o_ready // Byte accepted
);
    logic [7:0] q[$];
    // A stalled host takes nothing, like a host between transfers
    assign o_ready = !i_stall;
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            q.delete();
        end else if (i_valid && o_ready) begin
            q.push_back(i_data);
        end
    end
endmodule

/* File: testbench/testbench.sv */
/*
 * Bench of the report framer: register, touch, pen and stall tests.
 * Assumes the framer, its checker and the host model are compiled first.
 */
`timescale 1ns/10ps
module testbench;
    import htrf_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, tv = 0, pv = 0, stall = 0, bv, br, tr, pr, pn, oe;
    logic [3:0] addr = 4'h0;
    logic [31:0] wd = 32'h0, rdat, scan;
    logic [7:0] bd, b[36];
    htrf_touch_t t = '0;
    htrf_pen_t p = '0;
    int miscompares = 0, n_compared = 0, cyc = 0;
    htrf_framer #(.SCAN_TICK_CYC(10)) i_htrf_framer (.i_clk(clk), .i_sys_rst(rst),
        .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_touch_valid(tv),
        .i_touch(t), .o_touch_ready(tr), .i_pen_valid(pv), .i_pen(p), .o_pen_ready(pr),
        .o_byte_valid(bv), .o_byte_data(bd), .i_byte_ready(br), .o_message_pending_n(pn),
        .o_message_pending_n_oe(oe));
    htrf_host_model i_htrf_host_model (.i_clk(clk), .i_sys_rst(rst), .i_valid(bv),
        .i_data(bd), .i_stall(stall), .o_ready(br));
    initial begin
        forever #5 clk = ~clk;
    end
    // Hang guard; the tests need well under this
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a; wd <= d; wr <= w; rd <= !w;
        @(posedge clk);
        wr <= 1'b0; rd <= 1'b0;
        #1;
    endtask
    // Offer an event, hold it until taken; the scan value is read first
    task automatic offer(logic pen);
        bus(1'b0, 4'h8, 32'h0);
        scan = rdat;
        @(posedge clk);
        if (pen) pv <= 1'b1; else tv <= 1'b1;
        do @(posedge clk); while (!(pen ? pr : tr));
        pv <= 1'b0; tv <= 1'b0;
    endtask
    task automatic get(int n);
        for (int i = 0; i < n; i++) begin
            while (i_htrf_host_model.q.size() == 0) @(posedge clk);
            b[i] = i_htrf_host_model.q.pop_front();
        end
    endtask
    task automatic check_touch(logic g, int o);
        logic [7:0] e[18];
        e = '{8'h01, t.status, t.touch_num, t.x[7:0], {4'h0, t.x[11:8]},
            g ? t.x_alt[7:0] : 8'h0, g ? {4'h0, t.x_alt[11:8]} : 8'h0, t.y[7:0],
            {4'h0, t.y[11:8]}, g ? t.y_alt[7:0] : 8'h0, g ? {4'h0, t.y_alt[11:8]} : 8'h0,
            g ? t.width : 8'h0, 8'h0, g ? t.height : 8'h0, 8'h0, b[o+15], b[o+16], t.count};
        for (int k = 0; k < 18; k++) check(b[o+k], e[k]);
        check(16'({b[o+16], b[o+15]} - scan[15:0]) <= 16'h1, 1'b1);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 4'h0, 32'h0);
        check(rdat, 32'h0);
        bus(1'b0, 4'hc, 32'h0);
        check(rdat, 32'h0);
        $display("test registers done");
        t <= '{8'h81, 8'h00, 12'habc, 12'h123, 12'h456, 12'h789, 8'h33, 8'h44, 8'h02};
        offer(1'b0);
        get(18);
        check_touch(1'b0, 0);
        bus(1'b1, 4'h0, 32'h1);
        bus(1'b0, 4'h0, 32'h0);
        check(rdat, 32'h1);
        t.touch_num <= 8'h01;
        offer(1'b0);
        get(18);
        check_touch(1'b1, 0);
        $display("test touch done");
        for (int v = 0; v < 2; v++) begin
            p <= '{v[0], !v[0], v[0], !v[0], 16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 8'h5a};
            offer(1'b1);
            get(11);
            check(b[0], 8'h06);
            check(b[1], {3'h0, !v[0], 1'b0, v[0], !v[0], v[0]});
            check({b[5], b[4], b[3], b[2]}, 32'h56781234);
            check({b[9], b[8], b[7], b[6]}, 32'hdef09abc);
            check(b[10], 8'h5a);
        end
        $display("test pen done");
        stall <= 1'b1;
        offer(1'b0);
        repeat (40) @(posedge clk);
        check(tr, 1'b0);
        check(oe ? 1'b0 : 1'b1, 1'b0);
        check(pn, 1'b0);
        bus(1'b0, 4'h4, 32'h0);
        check(rdat, 32'h110);
        stall <= 1'b0;
        offer(1'b0);
        get(36);
        check_touch(1'b1, 18);
        repeat (5) @(posedge clk);
        check(oe ? 1'b0 : 1'b1, 1'b1);
        $display("test stall done");
        end_of_test();
    end
endmodule
